// ### rtl/dual_dac_pkg.sv
// Shared constants and types of the dual converter serial control block
package dual_dac_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned CNT_W  = 5;

  // Command word field positions
  localparam int unsigned CTRL_LOAD_HI       = 15;
  localparam int unsigned CTRL_LOAD_LO       = 14;
  localparam int unsigned CTRL_CHANNEL_SEL   = 13;
  localparam int unsigned CTRL_POWERDOWN_SEL = 12;
  localparam int unsigned PD_TERM_HI         = 11;
  localparam int unsigned PD_TERM_LO         = 10;

  // Bits received before a word is complete
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] LAST_BIT  = 5'h0F;
  localparam logic [4:0] CNT_RESET = 5'h00;

  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [11:0] CODE_RESET = 12'h000;

  // Pin bundle positions for the input synchroniser
  localparam int unsigned PIN_SCLK    = 0;
  localparam int unsigned PIN_FRAME   = 1;
  localparam int unsigned PIN_SDATA   = 2;
  localparam int unsigned PIN_CHAIN   = 3;
  localparam int unsigned PIN_CLEAR_N = 4;
  localparam int unsigned PIN_COUNT   = 5;
  // Serial clock, frame select and clear idle high, so reset shows no false edge
  localparam logic [4:0] PIN_RESET = 5'h13;

  typedef enum logic [1:0] {
    TERM_HIZ    = 2'h0,
    TERM_LOW_R  = 2'h1,
    TERM_HIGH_R = 2'h2
  } term_type;

endpackage : dual_dac_pkg

// ### rtl/pin_sync.sv
// Two-stage pin synchroniser with edge detection per bit
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned         WIDTH     = 5,
  parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;
  } sync_state_type;

  sync_state_type state_q;
  sync_state_type state_d;

  always_comb begin
    state_d        = state_q;
    state_d.meta   = pinIn;
    state_d.stable = state_q.meta;
    state_d.prev   = state_q.stable;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= '{meta: RESET_VAL, stable: RESET_VAL, prev: RESET_VAL};
    end else begin
      state_q <= state_d;
    end
  end

  // Edges look only at the second stage and its delayed copy
  for (genvar i = 0; i < WIDTH; i++) begin : g_edge
    assign level[i] = state_q.stable[i];
    assign rise[i]  = state_q.stable[i] & ~state_q.prev[i];
    assign fall[i]  = ~state_q.stable[i] & state_q.prev[i];
  end

endmodule : pin_sync

// ### rtl/word_decoder.sv
// Command word decoder: next register and power state of both channels
`timescale 1ns/1ps
module word_decoder (
  input  wire logic [15:0]          word,
  input  wire logic [11:0]          inA,
  input  wire logic [11:0]          inB,
  input  wire logic [11:0]          dacA,
  input  wire logic [11:0]          dacB,
  input  wire logic                 pdA,
  input  wire logic                 pdB,
  input  dual_dac_pkg::term_type    termA,
  input  dual_dac_pkg::term_type    termB,
  output logic      [11:0]          inANext,
  output logic      [11:0]          inBNext,
  output logic      [11:0]          dacANext,
  output logic      [11:0]          dacBNext,
  output logic                      pdANext,
  output logic                      pdBNext,
  output dual_dac_pkg::term_type    termANext,
  output dual_dac_pkg::term_type    termBNext
);

  logic [1:0]             load;
  logic                   chSel;
  logic                   pdCmd;
  logic [11:0]            data;
  logic [1:0]             pdCode;
  dual_dac_pkg::term_type term;

  always_comb begin
    load   = {word[dual_dac_pkg::CTRL_LOAD_HI], word[dual_dac_pkg::CTRL_LOAD_LO]};
    chSel  = word[dual_dac_pkg::CTRL_CHANNEL_SEL];
    pdCmd  = word[dual_dac_pkg::CTRL_POWERDOWN_SEL];
    data   = word[11:0];
    pdCode = {word[dual_dac_pkg::PD_TERM_HI], word[dual_dac_pkg::PD_TERM_LO]};
    unique case (pdCode)
      2'h1:    term = dual_dac_pkg::TERM_LOW_R;
      2'h2:    term = dual_dac_pkg::TERM_HIGH_R;
      default: term = dual_dac_pkg::TERM_HIZ;
    endcase
    inANext   = inA;
    inBNext   = inB;
    dacANext  = dacA;
    dacBNext  = dacB;
    pdANext   = pdA;
    pdBNext   = pdB;
    termANext = termA;
    termBNext = termB;
    if (pdCmd) begin
      // Channel A unless B alone, channel B unless A alone
      if (load != 2'h2) begin
        pdANext   = 1'b1;
        termANext = term;
      end
      if (load != 2'h1) begin
        pdBNext   = 1'b1;
        termBNext = term;
      end
    end else begin
      unique case (load)
        2'h0: begin
          if (chSel) inBNext = data;
          else inANext = data;
        end
        2'h1: begin
          inANext  = data;
          dacANext = data;
          pdANext  = 1'b0;
          if (chSel) begin
            dacBNext = inB;
            pdBNext  = 1'b0;
          end
        end
        2'h2: begin
          inBNext  = data;
          dacBNext = data;
          pdBNext  = 1'b0;
          if (chSel) begin
            dacANext = inA;
            pdANext  = 1'b0;
          end
        end
        2'h3: begin
          pdANext = 1'b0;
          pdBNext = 1'b0;
          if (chSel) begin
            dacANext = inA;
            dacBNext = inB;
          end else begin
            inANext  = data;
            inBNext  = data;
            dacANext = data;
            dacBNext = data;
          end
        end
      endcase
    end
  end

endmodule : word_decoder

// ### rtl/dual_dac_serial_control.sv
// Serial command front end and register set of a dual 12-bit converter
// Operation
// - Power down one or both, three terminations
// - Clear low zeroes outputs and registers
// - After clear, update waits for frame high
// - Sixteen-bit word: four control, twelve data
// - Data is unsigned straight binary
// - MSB first; two top bits pick registers
// - Third bit picks channel A, B, both
// - Fourth bit picks data or power-down
// - Both top bits set update both channels
// - Data accepted only while frame low
// - Shift on serial clock falls, sixteen pulses
// - No chain: execute at sixteenth fall
// - No chain: early frame rise drops word
// - Chain: output is input delayed sixteen
// - Chain: execute last word at frame rise
// - Chain output released unless chaining framed
// - Chain: frame toggles need a full clock pulse
// - Termination and channel of power-down
// - Store, update and cross-copy data commands
// - Power-up clears registers, zero outputs
`timescale 1ns/1ps
module dual_dac_serial_control (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               frameSelN,
  input  wire logic               serialClk,
  input  wire logic               serialIn,
  input  wire logic               chainEnable,
  input  wire logic               asyncClearN,
  output logic                    chainOut,
  output logic                    chainOutEn,
  output logic      [11:0]        dacCodeA,
  output logic      [11:0]        dacCodeB,
  output logic                    powerDownA,
  output logic                    powerDownB,
  output dual_dac_pkg::term_type  termSelA,
  output dual_dac_pkg::term_type  termSelB,
  output logic                    updateStrobe
);

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [15:0]            shiftReg;
    logic [4:0]             bitCount;
    logic                   stale;
    logic                   chainInit;
    logic [11:0]            inA;
    logic [11:0]            inB;
    logic [11:0]            dacA;
    logic [11:0]            dacB;
    logic                   pdA;
    logic                   pdB;
    dual_dac_pkg::term_type termA;
    dual_dac_pkg::term_type termB;
    logic                   chain_out;
    logic                   sdoEn;
    logic                   update;
  } ctrl_state_type;

  ctrl_state_type state_q;
  ctrl_state_type state_d;

  //////////////////////////////////////////////////////////////////////////////

  logic [4:0] pinRaw;
  logic [4:0] pinLevel;
  logic [4:0] pinRise;
  logic [4:0] pinFall;

  assign pinRaw = {asyncClearN, chainEnable, serialIn, frameSelN, serialClk};

  // Serial clock and data share one delay, so each sample stays aligned
  pin_sync #(
    .WIDTH     (dual_dac_pkg::PIN_COUNT),
    .RESET_VAL (dual_dac_pkg::PIN_RESET)
  ) u_pin_sync (
    .clk    (clk),
    .resetn (resetn),
    .pinIn  (pinRaw),
    .level  (pinLevel),
    .rise   (pinRise),
    .fall   (pinFall)
  );

  logic sclkFall;
  logic frameLow;
  logic frameRise;
  logic frameFall;
  logic sdata;
  logic chainMode;
  logic clearing;

  assign sclkFall  = pinFall[dual_dac_pkg::PIN_SCLK];
  assign frameLow  = ~pinLevel[dual_dac_pkg::PIN_FRAME];
  assign frameRise = pinRise[dual_dac_pkg::PIN_FRAME];
  assign frameFall = pinFall[dual_dac_pkg::PIN_FRAME];
  assign sdata     = pinLevel[dual_dac_pkg::PIN_SDATA];
  assign chainMode = pinLevel[dual_dac_pkg::PIN_CHAIN];
  assign clearing  = ~pinLevel[dual_dac_pkg::PIN_CLEAR_N];

  //////////////////////////////////////////////////////////////////////////////

  logic        shifting;
  logic        execNoChain;
  logic        execChain;
  logic        execute;
  logic [15:0] shiftNext;
  logic [15:0] execWord;

  // Shifting stops after sixteen bits unless the chain passes data on
  assign shifting = sclkFall && frameLow && !state_q.stale
                    && !state_q.chainInit && !frameFall
                    && (chainMode || state_q.bitCount != dual_dac_pkg::WORD_BITS);

  assign shiftNext = {state_q.shiftReg[14:0], sdata};

  assign execNoChain = shifting && !chainMode
                       && state_q.bitCount == dual_dac_pkg::LAST_BIT;

  // A partial chained frame is dropped as in plain mode
  assign execChain = frameRise && chainMode && !state_q.stale
                     && state_q.bitCount == dual_dac_pkg::WORD_BITS;

  assign execute  = !clearing && (execNoChain || execChain);
  assign execWord = execNoChain ? shiftNext : state_q.shiftReg;

  logic [11:0]            inANext;
  logic [11:0]            inBNext;
  logic [11:0]            dacANext;
  logic [11:0]            dacBNext;
  logic                   pdANext;
  logic                   pdBNext;
  dual_dac_pkg::term_type termANext;
  dual_dac_pkg::term_type termBNext;

  word_decoder u_word_decoder (
    .word      (execWord),
    .inA       (state_q.inA),
    .inB       (state_q.inB),
    .dacA      (state_q.dacA),
    .dacB      (state_q.dacB),
    .pdA       (state_q.pdA),
    .pdB       (state_q.pdB),
    .termA     (state_q.termA),
    .termB     (state_q.termB),
    .inANext   (inANext),
    .inBNext   (inBNext),
    .dacANext  (dacANext),
    .dacBNext  (dacBNext),
    .pdANext   (pdANext),
    .pdBNext   (pdBNext),
    .termANext (termANext),
    .termBNext (termBNext)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    state_d        = state_q;
    state_d.update = 1'b0;
    state_d.sdoEn  = chainMode && frameLow;
    if (frameFall) begin
      state_d.bitCount = dual_dac_pkg::CNT_RESET;
    end else if (shifting) begin
      state_d.shiftReg = shiftNext;
      if (state_q.bitCount != dual_dac_pkg::WORD_BITS) begin
        state_d.bitCount = state_q.bitCount + 5'h01;
      end
    end
    // Register end feeds the next device: sixteen clocks of delay
    if (shifting && chainMode) begin
      state_d.chain_out = state_q.shiftReg[15];
    end
    // Chained interface re-arms on a clock fall after the frame or on a clear
    if (frameRise && chainMode) begin
      state_d.chainInit = 1'b1;
    end else if (sclkFall && !frameLow) begin
      state_d.chainInit = 1'b0;
    end
    // A frame open during clear is not trusted; frame high re-arms
    if (!frameLow) begin
      state_d.stale = 1'b0;
    end
    if (frameRise && !chainMode) begin
      state_d.bitCount = dual_dac_pkg::CNT_RESET;
    end
    if (execute) begin
      state_d.inA    = inANext;
      state_d.inB    = inBNext;
      state_d.dacA   = dacANext;
      state_d.dacB   = dacBNext;
      state_d.pdA    = pdANext;
      state_d.pdB    = pdBNext;
      state_d.termA  = termANext;
      state_d.termB  = termBNext;
      state_d.update = 1'b1;
    end
    if (clearing) begin
      state_d.shiftReg  = dual_dac_pkg::WORD_RESET;
      state_d.bitCount  = dual_dac_pkg::CNT_RESET;
      state_d.inA       = dual_dac_pkg::CODE_RESET;
      state_d.inB       = dual_dac_pkg::CODE_RESET;
      state_d.dacA      = dual_dac_pkg::CODE_RESET;
      state_d.dacB      = dual_dac_pkg::CODE_RESET;
      state_d.pdA       = 1'b0;
      state_d.pdB       = 1'b0;
      state_d.termA     = dual_dac_pkg::TERM_HIZ;
      state_d.termB     = dual_dac_pkg::TERM_HIZ;
      state_d.chain_out       = 1'b0;
      state_d.chainInit = 1'b0;
      state_d.stale     = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= '{
        shiftReg:  dual_dac_pkg::WORD_RESET,
        bitCount:  dual_dac_pkg::CNT_RESET,
        stale:     1'b0,
        chainInit: 1'b0,
        inA:       dual_dac_pkg::CODE_RESET,
        inB:       dual_dac_pkg::CODE_RESET,
        dacA:      dual_dac_pkg::CODE_RESET,
        dacB:      dual_dac_pkg::CODE_RESET,
        pdA:       1'b0,
        pdB:       1'b0,
        termA:     dual_dac_pkg::TERM_HIZ,
        termB:     dual_dac_pkg::TERM_HIZ,
        chain_out:       1'b0,
        sdoEn:     1'b0,
        update:    1'b0
      };
    end else begin
      state_q <= state_d;
    end
  end

  assign chainOut     = state_q.chain_out;
  assign chainOutEn   = state_q.sdoEn;
  assign dacCodeA     = state_q.dacA;
  assign dacCodeB     = state_q.dacB;
  assign powerDownA   = state_q.pdA;
  assign powerDownB   = state_q.pdB;
  assign termSelA     = state_q.termA;
  assign termSelB     = state_q.termB;
  assign updateStrobe = state_q.update;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!resetn);

  a_clear_zeroes: assert property (
    clearing |=> dacCodeA == 12'h000 && dacCodeB == 12'h000
                 && !powerDownA && !powerDownB && !updateStrobe
  ) else $error("clear did not zero the outputs");

  a_frame_rearm: assert property (
    $fell(clearing) ##1 (!frameRise && !clearing) [*2] |=> !updateStrobe
  ) else $error("update before first frame rise after clear");

  a_nochain_exec: assert property (
    execNoChain && !clearing |=> updateStrobe ##1 !updateStrobe
  ) else $error("word not executed at sixteenth fall");

  a_partial_drop: assert property (
    frameRise && !chainMode && state_q.bitCount != dual_dac_pkg::WORD_BITS
    |=> !updateStrobe && $stable(dacCodeA) && $stable(dacCodeB)
  ) else $error("partial word changed state");

  a_chain_exec: assert property (
    chainMode && !frameRise |=> !updateStrobe
  ) else $error("chained word executed without frame rise");

  a_chain_load: assert property (
    execChain && !clearing |=> updateStrobe
  ) else $error("chained word missed at frame rise");

  a_chain_hiz: assert property (
    !frameLow || !chainMode |=> !chainOutEn
  ) else $error("chain output driven outside chained frame");

  a_chain_delay: assert property (
    shifting && chainMode && !clearing
    |=> chainOut == $past(state_q.shiftReg[15])
  ) else $error("chain output not sixteen bits behind input");

  a_shift_bit: assert property (
    shifting && !clearing |=> state_q.shiftReg[0] == $past(sdata)
                             && state_q.shiftReg[15:1] == $past(state_q.shiftReg[14:0])
  ) else $error("serial bit not shifted in");

  a_count_reset: assert property (
    frameFall && !clearing |=> state_q.bitCount == dual_dac_pkg::CNT_RESET
  ) else $error("bit count not restarted by frame fall");

  a_frame_gate: assert property (
    !frameLow && !frameFall |=> $stable(state_q.shiftReg) || $past(clearing)
  ) else $error("data shifted while frame high");

  // Output registers move only on a decoded word or a clear
  a_outputs_hold: assert property (
    !execute && !clearing
    |=> $stable(dacCodeA) && $stable(dacCodeB) && $stable(powerDownA) && $stable(powerDownB)
  ) else $error("outputs changed without a command");

  a_stale_block: assert property (
    state_q.stale |=> !updateStrobe
  ) else $error("update from a frame open during clear");

  a_update_pulse: assert property (
    updateStrobe |=> !updateStrobe
  ) else $error("update strobe longer than one cycle");

  a_count_limit: assert property (
    state_q.bitCount <= dual_dac_pkg::WORD_BITS
  ) else $error("bit count beyond one word");

  a_chain_arm: assert property (
    frameRise && chainMode && !clearing |=> state_q.chainInit
  ) else $error("chained interface not held after frame rise");

  a_chain_release: assert property (
    state_q.chainInit && sclkFall && !frameLow && !frameRise && !clearing
    |=> !state_q.chainInit
  ) else $error("chained interface not re-armed by clock fall");

  c_plain_update: cover property (execNoChain ##1 updateStrobe);
  c_chain_update: cover property (execChain ##1 updateStrobe);
  c_power_down:   cover property (updateStrobe && powerDownA && powerDownB);
  c_partial_drop: cover property (frameRise && !chainMode && state_q.bitCount != 5'h00);
  c_clear_rearm:  cover property ($fell(state_q.stale));

endmodule : dual_dac_serial_control

// ### verif/host_model.sv
// Host serial master model driving frame select, serial clock and data
`timescale 1ns/1ps
module host_model (
  input  wire logic clk,
  output logic      frameSelN,
  output logic      serialClk,
  output logic      serialIn
);
  initial begin
    frameSelN = 1'b1;
    serialClk = 1'b1;
    serialIn  = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  // Clock idles high and stands still between frames, except one pulse after a chained frame
  task automatic frame(input logic [31:0] bits, input int n, input bit chain);
    int half;
    half = chain ? 7 : 5;
    frameSelN = 1'b0;
    hold(half);
    for (int j = 0; j < n; j++) begin
      serialIn = bits[n-1-j];
      hold(half);
      serialClk = 1'b0;
      hold(half);
      serialClk = 1'b1;
    end
    hold(half);
    frameSelN = 1'b1;
    // Released data line shows the inverse of its last bit
    serialIn = ~serialIn;
    if (chain) begin
      hold(half);
      serialClk = 1'b0;
      hold(half);
      serialClk = 1'b1;
    end
    hold(half);
  endtask : frame
endmodule : host_model

// ### verif/tb_top.sv
// Self-checking bench of the dual converter serial control block
`timescale 1ns/1ps
module tb_top;
  logic                   clk         = 1'b0;
  logic                   resetn      = 1'b0;
  logic                   chainEnable = 1'b0;
  logic                   asyncClearN = 1'b1;
  logic                   frameSelN, serialClk, serialIn;
  logic                   chainOut, chainOutEn, updateStrobe, powerDownA, powerDownB;
  logic [11:0]            dacCodeA, dacCodeB;
  dual_dac_pkg::term_type termSelA, termSelB;
  logic [31:0]            sent;
  int                     mismatches = 0;
  int                     num_checks = 0;
  int                     strobes    = 0;
  int                     fallIdx    = 0;
  int                     sentN      = 0;
  int                     inA = 0, inB = 0, dacA = 0, dacB = 0;
  int                     pdA = 0, pdB = 0, termA = 0, termB = 0;

  always #4 clk = ~clk;

  dual_dac_serial_control dut (
    .clk          (clk),
    .resetn       (resetn),
    .frameSelN    (frameSelN),
    .serialClk    (serialClk),
    .serialIn     (serialIn),
    .chainEnable  (chainEnable),
    .asyncClearN  (asyncClearN),
    .chainOut     (chainOut),
    .chainOutEn   (chainOutEn),
    .dacCodeA     (dacCodeA),
    .dacCodeB     (dacCodeB),
    .powerDownA   (powerDownA),
    .powerDownB   (powerDownB),
    .termSelA     (termSelA),
    .termSelB     (termSelB),
    .updateStrobe (updateStrobe)
  );

  host_model host (
    .clk       (clk),
    .frameSelN (frameSelN),
    .serialClk (serialClk),
    .serialIn  (serialIn)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  // Reference model of both channels' registers
  function automatic void apply(input logic [15:0] w);
    int c;
    int s;
    c = w[15:14];
    s = w[13];
    if (w[12]) begin
      if (c != 2) pdA = 1;
      if (c != 2) termA = (w[11:10] == 2'h1) ? 1 : (w[11:10] == 2'h2) ? 2 : 0;
      if (c != 1) pdB = 1;
      if (c != 1) termB = (w[11:10] == 2'h1) ? 1 : (w[11:10] == 2'h2) ? 2 : 0;
    end else begin
      if (c == 1 || (c == 3 && s == 0) || (c == 0 && s == 0)) inA = w[11:0];
      if (c == 2 || (c == 3 && s == 0) || (c == 0 && s == 1)) inB = w[11:0];
      if (c == 1 || c == 3 || (c == 2 && s == 1)) begin
        dacA = inA;
        pdA  = 0;
      end
      if (c == 2 || c == 3 || (c == 1 && s == 1)) begin
        dacB = inB;
        pdB  = 0;
      end
    end
  endfunction : apply

  task automatic compare;
    check(dacCodeA, dacA);
    check(dacCodeB, dacB);
    check(powerDownA, pdA);
    check(powerDownB, pdB);
    check(termSelA, termA);
    check(termSelB, termB);
  endtask : compare

  function automatic void clear_model;
    inA   = 0;
    inB   = 0;
    dacA  = 0;
    dacB  = 0;
    pdA   = 0;
    pdB   = 0;
    termA = 0;
    termB = 0;
  endfunction : clear_model

  // Clear pulse after lead cycles; the model follows the registers to zero
  task automatic pulse_clear(input int lead);
    repeat (lead) @(posedge clk);
    #1;
    asyncClearN = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    asyncClearN = 1'b1;
    clear_model();
    repeat (4) @(posedge clk);
    #1;
  endtask : pulse_clear

  // One frame, then strobe count, released chain output and register state
  task automatic run(input logic [31:0] bits, input int n, input bit exec);
    int s0;
    s0      = strobes;
    sent    = bits;
    sentN   = n;
    fallIdx = 0;
    host.frame(bits, n, chainEnable);
    repeat (8) @(posedge clk);
    #1;
    check(strobes - s0, exec);
    check(chainOutEn, 1'b0);
    if (exec && chainEnable) apply(bits[15:0]);
    if (exec && !chainEnable) apply(16'(bits >> (n - 16)));
    compare();
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (updateStrobe === 1'b1) strobes <= strobes + 1;
  end

  // Chained output seen at a fall carries the bit shifted seventeen falls earlier
  always @(negedge serialClk) begin
    if (frameSelN === 1'b0) begin
      check(chainOutEn, chainEnable);
      if (chainEnable && fallIdx >= 17) check(chainOut, sent[sentN + 16 - fallIdx]);
      fallIdx++;
    end
  end

  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    r = $urandom(99684);
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    compare();
    // Every control nibble and termination code
    for (int i = 0; i < 64; i++) begin
      r = $urandom();
      run({16'h0000, i[3:0], i[5:4], r[9:0]}, 16, 1'b1);
    end
    r = $urandom();
    run(r & 32'h000003FF, 10, 1'b0);
    run({16'h0000, 4'h4, r[11:0]}, 16, 1'b1);
    r = $urandom();
    run(r & 32'h000FFFFF, 20, 1'b1);
    chainEnable = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    r = $urandom();
    run(r, 32, 1'b1);
    run(r & 32'h00000FFF, 12, 1'b0);
    r = $urandom();
    run(r & 32'h0000FFFF, 16, 1'b1);
    chainEnable = 1'b0;
    asyncClearN = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    clear_model();
    compare();
    asyncClearN = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    // A one-bit frame after the clear is dropped without executing
    run(32'h00000001, 1, 1'b0);
    r = $urandom();
    run({16'h0000, 4'h6, r[11:0]}, 16, 1'b1);
    // A clear inside an open frame voids that frame; a fresh frame then executes
    fork
      run({16'h0000, 4'hC, r[11:0]}, 16, 1'b0);
      pulse_clear(40);
    join
    pulse_clear(0);
    r = $urandom();
    run({16'h0000, 4'h4, r[11:0]}, 16, 1'b1);
    report_and_stop();
  end
endmodule : tb_top
